/* File: include/arpwm_pkg.sv */
// Package: register map, field positions and reset values of the autoreload PWM timer
package arpwm_pkg;
   // Register byte offsets (8-bit register port)
   localparam logic [7:0] ADDR_CSR = 8'h0d;
   localparam logic [7:0] ADDR_CNT_HI = 8'h0e;
   localparam logic [7:0] ADDR_CNT_LO = 8'h0f;
   localparam logic [7:0] ADDR_RLD_HI = 8'h10;
   localparam logic [7:0] ADDR_RLD_LO = 8'h11;
   localparam logic [7:0] ADDR_OUT_EN = 8'h12;
   localparam logic [7:0] ADDR_CH_CSR0 = 8'h13;
   localparam logic [7:0] ADDR_DUTY0_HI = 8'h17;
   localparam logic [7:0] ADDR_CAP_HI = 8'h1f;
   localparam logic [7:0] ADDR_CAP_LO = 8'h20;
   localparam logic [7:0] ADDR_XFER = 8'h21;
   localparam logic [7:0] ADDR_BREAK = 8'h22;
   // Control/status field positions
   localparam int CSR_CAP_FLAG = 6;
   localparam int CSR_CAP_IE = 5;
   localparam int CSR_CLK_HI = 4;
   localparam int CSR_CLK_LO = 3;
   localparam int CSR_OVF_FLAG = 2;
   localparam int CSR_OVF_IE = 1;
   localparam int CSR_CMP_IE = 0;
   // Break control field positions
   localparam int BRK_ACTIVE = 5;
   localparam int BRK_PIN_EN = 4;
   // Counter clock selections
   localparam logic [1:0] CLK_OFF = 2'h0;
   localparam logic [1:0] CLK_TIMEBASE = 2'h1;
   localparam logic [1:0] CLK_CPU = 2'h2;
   localparam logic [1:0] CLK_FAST = 2'h3;
   // Reset values and limits
   localparam logic [11:0] CNT_MAX = 12'hfff;
   localparam logic [11:0] CNT_RESET = 12'h000;
   localparam logic XFER_RESET = 1'b1;
endpackage : arpwm_pkg

/* File: src/arpwm_timer.sv */
// Autoreload 12-bit PWM timer with capture, compare and break
`timescale 1ns/1ps
`default_nettype none
module arpwm_timer #(
   parameter int CHANNELS = 4
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // Counter clock enables, one-cycle pulses on mclk_i
   input wire logic timebase_clock_i,
   input wire logic cpu_tick_i,
   input wire logic fast_tick_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Pins
   input wire logic capture_pin_i,
   input wire logic break_n_i,
   output logic [3:0] pwm_o,
   output logic [3:0] pwm_active_o,
   // Interrupt requests
   output logic irq_cmp_cap_o,
   output logic irq_ovf_o
);
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [2:0] cap_sync;
      logic [1:0] brk_sync;
      logic cap_flag;
      logic cap_ie;
      logic [1:0] clk_sel;
      logic ovf_flag;
      logic ovf_ie;
      logic cmp_ie;
      logic [11:0] counter;
      logic [11:0] reload;
      logic [3:0] out_en;
      logic [3:0] pin_owned;
      logic [3:0] polarity;
      logic [3:0] pol_shadow;
      logic [3:0] cmp_flag;
      logic [47:0] duty;
      logic [47:0] duty_shadow;
      logic [3:0] pwm_raw;
      logic [11:0] captured;
      logic xfer;
      logic brk_active;
      logic brk_pin_en;
      logic [3:0] brk_pattern;
      logic [7:0] rdata;
   } arpwm_state_t;

   arpwm_state_t st;
   arpwm_state_t next_st;
   logic rst_n;
   logic tick;
   logic ovf_evt;
   logic cap_edge;
   logic [3:0] match;
   logic [7:0] ch_idx;
   logic [7:0] duty_idx;
   logic pwm_ok;
   logic [11:0] cnt_step;

   assign rst_n = st.rst_sync[1];

   always_comb begin
      // counter clock enable from the selected source
      case (st.clk_sel)
         arpwm_pkg::CLK_OFF: tick = 1'b0;
         arpwm_pkg::CLK_TIMEBASE: tick = timebase_clock_i;
         arpwm_pkg::CLK_CPU: tick = cpu_tick_i;
         arpwm_pkg::CLK_FAST: tick = fast_tick_i;
         default: tick = 1'b0;
      endcase
   end

   assign ovf_evt = tick && (st.counter == arpwm_pkg::CNT_MAX);
   assign cap_edge = st.cap_sync[2] ^ st.cap_sync[1];
   assign pwm_ok = (st.clk_sel != arpwm_pkg::CLK_TIMEBASE);
   assign ch_idx = reg_addr_i - arpwm_pkg::ADDR_CH_CSR0;
   assign duty_idx = reg_addr_i - arpwm_pkg::ADDR_DUTY0_HI;
   // Value the counter takes on this tick
   assign cnt_step = ovf_evt ? st.reload : st.counter + 12'h001;

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_match
         // duty value is the compare target, zero disables compare
         // Match on the tick that brings the counter onto the duty value
         assign match[g] = tick && pwm_ok && (st.duty_shadow[g*12 +: 12] != 12'h000)
            && (cnt_step == st.duty_shadow[g*12 +: 12]);
      end
   endgenerate

   always_comb begin
      next_st = st;
      next_st.rst_sync = {st.rst_sync[0], 1'b1};
      // two-stage synchronisers, third stage for edge detect
      next_st.cap_sync = {st.cap_sync[1:0], capture_pin_i};
      next_st.brk_sync = {st.brk_sync[0], break_n_i};
      next_st.rdata = 8'h00;

      // Register writes
      if (reg_wr_i) begin
         case (reg_addr_i)
            arpwm_pkg::ADDR_CSR: begin
               next_st.cap_ie = reg_wdata_i[arpwm_pkg::CSR_CAP_IE];
               next_st.clk_sel = reg_wdata_i[arpwm_pkg::CSR_CLK_HI:arpwm_pkg::CSR_CLK_LO];
               next_st.ovf_ie = reg_wdata_i[arpwm_pkg::CSR_OVF_IE];
               next_st.cmp_ie = reg_wdata_i[arpwm_pkg::CSR_CMP_IE];
            end
            arpwm_pkg::ADDR_RLD_HI: next_st.reload[11:8] = reg_wdata_i[3:0];
            arpwm_pkg::ADDR_RLD_LO: next_st.reload[7:0] = reg_wdata_i;
            arpwm_pkg::ADDR_OUT_EN: begin
               // enables sit in the even bit positions
               next_st.out_en = {reg_wdata_i[6], reg_wdata_i[4], reg_wdata_i[2], reg_wdata_i[0]};
            end
            arpwm_pkg::ADDR_XFER: next_st.xfer = reg_wdata_i[0];
            arpwm_pkg::ADDR_BREAK: begin
               next_st.brk_active = reg_wdata_i[arpwm_pkg::BRK_ACTIVE];
               next_st.brk_pin_en = reg_wdata_i[arpwm_pkg::BRK_PIN_EN];
               next_st.brk_pattern = reg_wdata_i[3:0];
            end
            default: begin
               if (ch_idx < 8'(CHANNELS)) begin
                  next_st.polarity[ch_idx[1:0]] = reg_wdata_i[1];
               end
               if (duty_idx < 8'(2 * CHANNELS)) begin
                  if (!duty_idx[0]) begin
                     next_st.duty[{duty_idx[2:1], 3'h0} + {duty_idx[2:1], 2'h0} + 8 +: 4] =
                        reg_wdata_i[3:0];
                  end else begin
                     next_st.duty[{duty_idx[2:1], 3'h0} + {duty_idx[2:1], 2'h0} +: 8] =
                        reg_wdata_i;
                  end
               end
            end
         endcase
      end

      // Register reads, data stands one cycle later; reads clear flags
      if (reg_rd_i) begin
         case (reg_addr_i)
            arpwm_pkg::ADDR_CSR: begin
               next_st.rdata = {1'b0, st.cap_flag, st.cap_ie, st.clk_sel, st.ovf_flag,
                  st.ovf_ie, st.cmp_ie};
               next_st.ovf_flag = 1'b0;
            end
            arpwm_pkg::ADDR_CNT_HI: next_st.rdata = {4'h0, st.counter[11:8]};
            arpwm_pkg::ADDR_CNT_LO: next_st.rdata = st.counter[7:0];
            arpwm_pkg::ADDR_RLD_HI: next_st.rdata = {4'h0, st.reload[11:8]};
            arpwm_pkg::ADDR_RLD_LO: next_st.rdata = st.reload[7:0];
            arpwm_pkg::ADDR_OUT_EN: begin
               next_st.rdata = {1'b0, st.out_en[3], 1'b0, st.out_en[2], 1'b0, st.out_en[1],
                  1'b0, st.out_en[0]};
            end
            arpwm_pkg::ADDR_CAP_HI: begin
               next_st.rdata = {4'h0, st.captured[11:8]};
               next_st.cap_flag = 1'b0;
            end
            arpwm_pkg::ADDR_CAP_LO: begin
               next_st.rdata = st.captured[7:0];
               next_st.cap_flag = 1'b0;
            end
            arpwm_pkg::ADDR_XFER: next_st.rdata = {7'h00, st.xfer};
            arpwm_pkg::ADDR_BREAK: begin
               next_st.rdata = {2'b00, st.brk_active, st.brk_pin_en, st.brk_pattern};
            end
            default: begin
               if (ch_idx < 8'(CHANNELS)) begin
                  next_st.rdata = {6'h00, st.polarity[ch_idx[1:0]], st.cmp_flag[ch_idx[1:0]]};
                  next_st.cmp_flag[ch_idx[1:0]] = 1'b0;
               end
               if (duty_idx < 8'(2 * CHANNELS)) begin
                  if (!duty_idx[0]) begin
                     next_st.rdata = {4'h0,
                        st.duty[{duty_idx[2:1], 3'h0} + {duty_idx[2:1], 2'h0} + 8 +: 4]};
                  end else begin
                     next_st.rdata = st.duty[{duty_idx[2:1], 3'h0} + {duty_idx[2:1], 2'h0} +: 8];
                  end
               end
            end
         endcase
      end

      // Counter with autoreload
      if (tick) begin
         if (ovf_evt) begin
            next_st.counter = st.reload;
         end else begin
            next_st.counter = st.counter + 12'h001;
         end
      end

      // Overflow: flag, shadow transfer, enabled outputs high except on the timebase clock
      if (ovf_evt) begin
         next_st.ovf_flag = 1'b1;
         if (st.xfer) begin
            next_st.duty_shadow = next_st.duty;
            next_st.pol_shadow = next_st.polarity;
            next_st.xfer = 1'b0;
         end
         next_st.pin_owned = st.out_en;
         next_st.pwm_raw = pwm_ok ? st.out_en : 4'h0;
      end

      // Compare match drives the channel low and raises its flag
      for (int i = 0; i < CHANNELS; i++) begin
         if (match[i]) begin
            next_st.cmp_flag[i] = 1'b1;
            next_st.pwm_raw[i] = 1'b0;
         end
      end
      for (int i = 0; i < CHANNELS; i++) begin
         if (st.out_en[i]) begin
            next_st.pin_owned[i] = 1'b1;
         end
      end

      // Input capture only while the old flag is clear; then a new edge wins over a read clear in the same cycle
      if (cap_edge && !st.cap_flag) begin
         next_st.captured = st.counter;
         next_st.cap_flag = 1'b1;
      end

      // Break: pin low latches the active bit
      if (st.brk_pin_en && !st.brk_sync[1]) begin
         next_st.brk_active = 1'b1;
      end
      if (next_st.brk_active) begin
         next_st.counter = arpwm_pkg::CNT_RESET;
         next_st.reload = 12'h000;
         next_st.duty = '0;
         next_st.duty_shadow = '0;
         next_st.out_en = 4'h0;
         next_st.pwm_raw = 4'h0;
      end
      // Leaving break hands the pins back to general-purpose I/O
      if (st.brk_active && !next_st.brk_active) begin
         next_st.pin_owned = 4'h0;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st <= '0;
         st.cap_sync <= 3'h0;
         st.brk_sync <= 2'h3;
         st.xfer <= arpwm_pkg::XFER_RESET;
      end else if (!rst_n) begin
         st.rst_sync <= next_st.rst_sync;
         st.cap_sync <= next_st.cap_sync;
         st.brk_sync <= next_st.brk_sync;
      end else begin
         st <= next_st;
      end
   end

   // Outputs: break pattern forced after the inverter
   assign pwm_o = st.brk_active ? st.brk_pattern : (st.pwm_raw ^ st.pol_shadow);
   assign pwm_active_o = st.brk_active ? 4'hf : st.pin_owned;
   assign reg_rdata_o = st.rdata;
   assign irq_cmp_cap_o = (st.cap_ie && st.cap_flag) || (st.cmp_ie && (|st.cmp_flag));
   assign irq_ovf_o = st.ovf_ie && st.ovf_flag;

   // Assertions
   overflow_reload_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      ovf_evt && !next_st.brk_active |=> st.counter == $past(st.reload))
      else $error("counter did not reload at overflow");
   overflow_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      ovf_evt |=> st.ovf_flag)
      else $error("overflow flag not set");
   capture_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      st.cap_flag && !(reg_rd_i && (reg_addr_i == arpwm_pkg::ADDR_CAP_LO)) |=>
      $stable(st.captured))
      else $error("capture changed while flag set");
   capture_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      cap_edge && !st.cap_flag |=> st.cap_flag && st.captured == $past(st.counter))
      else $error("capture not taken");
   stopped_count_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      st.clk_sel == arpwm_pkg::CLK_OFF && !next_st.brk_active |=> $stable(st.counter))
      else $error("counter moved while clock off");
   break_pattern_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      st.brk_active |-> pwm_o == st.brk_pattern)
      else $error("break pattern not on outputs");
   break_pin_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      st.brk_pin_en && !st.brk_sync[1] |=> st.brk_active && st.out_en == 4'h0)
      else $error("break pin not honoured");
   ovf_irq_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      irq_ovf_o |-> st.ovf_ie)
      else $error("overflow irq without enable");
   cmp_irq_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      !st.cmp_ie && !(st.cap_ie && st.cap_flag) |-> !irq_cmp_cap_o)
      else $error("compare irq not masked");
   xfer_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      ovf_evt && st.xfer && !(reg_wr_i && reg_addr_i == arpwm_pkg::ADDR_XFER) |=> !st.xfer)
      else $error("transfer bit not cleared");
   cmp_timebase_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      st.clk_sel == arpwm_pkg::CLK_TIMEBASE |=> (st.cmp_flag & ~$past(st.cmp_flag)) == 4'h0)
      else $error("compare flag set on timebase clock");
   cmp_flag_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      (|match) |=> (st.cmp_flag & $past(match)) == $past(match))
      else $error("compare flag not set on match");
   match_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      (|match) && !next_st.brk_active |=> (st.pwm_raw & $past(match)) == 4'h0)
      else $error("channel not driven low on match");
   ovf_high_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      ovf_evt && pwm_ok && match == 4'h0 && !next_st.brk_active |=>
      st.pwm_raw == $past(st.out_en))
      else $error("enabled channels not set at overflow");
   shadow_load_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      ovf_evt && st.xfer && !next_st.brk_active |=>
      st.duty_shadow == $past(next_st.duty) && st.pol_shadow == $past(next_st.polarity))
      else $error("shadow copies not loaded at overflow");
   shadow_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      !ovf_evt && !next_st.brk_active |=> $stable(st.duty_shadow) && $stable(st.pol_shadow))
      else $error("shadow copies changed between overflows");
   cap_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      !st.cap_flag && !cap_edge |=> !st.cap_flag)
      else $error("capture flag set without an edge");
   cap_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      reg_rd_i && (reg_addr_i == arpwm_pkg::ADDR_CAP_HI || reg_addr_i == arpwm_pkg::ADDR_CAP_LO)
      && st.cap_flag |=> !st.cap_flag)
      else $error("capture flag not cleared by read");
   ovf_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      reg_rd_i && reg_addr_i == arpwm_pkg::ADDR_CSR && !ovf_evt |=> !st.ovf_flag)
      else $error("overflow flag not cleared by read");
   count_step_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      tick && !ovf_evt && !next_st.brk_active |=> st.counter == $past(st.counter) + 12'h001)
      else $error("counter did not step on tick");
   break_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      st.brk_active |-> st.counter == arpwm_pkg::CNT_RESET && st.reload == 12'h000
      && st.duty == '0 && st.duty_shadow == '0 && st.out_en == 4'h0)
      else $error("break left timer state uncleared");
   break_top_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      reg_rd_i && reg_addr_i == arpwm_pkg::ADDR_BREAK |=> reg_rdata_o[7:6] == 2'h0)
      else $error("break register top bits not zero");
   pin_release_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      ovf_evt && !next_st.brk_active |=> st.pin_owned == $past(st.out_en))
      else $error("pin ownership not updated at overflow");
   cap_irq_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      st.cap_ie && st.cap_flag |-> irq_cmp_cap_o)
      else $error("capture irq missing");
   ovf_irq_on_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      st.ovf_ie && st.ovf_flag |-> irq_ovf_o)
      else $error("overflow irq missing");
endmodule // arpwm_timer
`default_nettype wire

/* File: testbench/arpwm_far_end.sv */
// Far-side model: capture signal source and active-low break source
`timescale 1ns/1ps
`default_nettype none
module arpwm_far_end (
   // Clock and commands from the bench
   input wire logic mclk_i,
   input wire logic cap_toggle_i,
   input wire logic brk_req_i,
   // Pins towards the timer
   output logic capture_pin_o,
   output logic break_n_o
);
   initial begin
      capture_pin_o = 1'b0;
      break_n_o = 1'b1;
   end
   // Edges land away from the sampling edge, as a real source would
   always @(posedge mclk_i) begin
      if (cap_toggle_i) begin
         capture_pin_o <= #13 ~capture_pin_o;
      end
      break_n_o <= #7 ~brk_req_i;
   end
endmodule // arpwm_far_end
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking testbench of the autoreload PWM timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic mclk_i;
   logic reset_n_i;
   logic [2:0] tick;
   logic [7:0] reg_addr_i;
   logic [7:0] reg_wdata_i;
   logic reg_wr_i;
   logic reg_rd_i;
   logic [7:0] reg_rdata_o;
   logic cap_tgl;
   logic brk_req;
   logic capture_pin_i;
   logic break_n_i;
   logic [3:0] pwm_o;
   logic [3:0] pwm_active_o;
   logic irq_cmp_cap_o;
   logic irq_ovf_o;
   int fail_count = 0;
   int n_checks = 0;

   arpwm_timer #(.CHANNELS(4)) i_arpwm_timer (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .timebase_clock_i(tick[0]), .cpu_tick_i(tick[1]), .fast_tick_i(tick[2]),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .capture_pin_i(capture_pin_i), .break_n_i(break_n_i),
      .pwm_o(pwm_o), .pwm_active_o(pwm_active_o),
      .irq_cmp_cap_o(irq_cmp_cap_o), .irq_ovf_o(irq_ovf_o));
   arpwm_far_end i_arpwm_far_end (
      .mclk_i(mclk_i), .cap_toggle_i(cap_tgl), .brk_req_i(brk_req),
      .capture_pin_o(capture_pin_i), .break_n_o(break_n_i));

   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   task automatic finish_test();
      if (fail_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask

   task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1 check(what, reg_rdata_o, exp);
   endtask

   // Counter clock pulses on one source for n cycles, then let the state settle
   task automatic run(input int sel, input int n);
      @(posedge mclk_i);
      tick[sel] <= 1'b1;
      repeat (n) @(posedge mclk_i);
      tick <= 3'h0;
      repeat (2) @(posedge mclk_i);
   endtask

   task automatic toggle_capture();
      @(posedge mclk_i);
      cap_tgl <= 1'b1;
      @(posedge mclk_i);
      cap_tgl <= 1'b0;
      repeat (8) @(posedge mclk_i);
   endtask

   task automatic reset_values();
      rdc("status", arpwm_pkg::ADDR_CSR, 8'h00);
      rdc("transfer", arpwm_pkg::ADDR_XFER, 8'h01);
      rdc("break", arpwm_pkg::ADDR_BREAK, 8'h00);
      rdc("enables", arpwm_pkg::ADDR_OUT_EN, 8'h00);
      rdc("unmapped", 8'h05, 8'h00);
   endtask

   task automatic clock_select();
      wr(arpwm_pkg::ADDR_CSR, 8'h10);
      run(1, 5);
      wr(arpwm_pkg::ADDR_CSR, 8'h08);
      run(0, 3);
      run(1, 3);
      wr(arpwm_pkg::ADDR_CSR, 8'h18);
      run(2, 2);
      wr(arpwm_pkg::ADDR_CSR, 8'h00);
      run(1, 4);
      // Low byte first, then high byte
      rdc("count lo", arpwm_pkg::ADDR_CNT_LO, 8'h0a);
      rdc("count hi", arpwm_pkg::ADDR_CNT_HI, 8'h00);
   endtask

   task automatic overflow();
      wr(arpwm_pkg::ADDR_RLD_HI, 8'h0f);
      wr(arpwm_pkg::ADDR_RLD_LO, 8'hfc);
      wr(arpwm_pkg::ADDR_CSR, 8'h12);
      run(1, 4085);
      check("ovf irq early", {7'h0, irq_ovf_o}, 8'h00);
      run(1, 1);
      check("ovf irq", {7'h0, irq_ovf_o}, 8'h01);
      rdc("reload lo", arpwm_pkg::ADDR_CNT_LO, 8'hfc);
      rdc("reload hi", arpwm_pkg::ADDR_CNT_HI, 8'h0f);
      wr(arpwm_pkg::ADDR_CSR, 8'h10);
      check("ovf masked", {7'h0, irq_ovf_o}, 8'h00);
      rdc("ovf flag", arpwm_pkg::ADDR_CSR, 8'h14);
      rdc("ovf cleared", arpwm_pkg::ADDR_CSR, 8'h10);
   endtask

   task automatic pwm_and_compare();
      wr(arpwm_pkg::ADDR_DUTY0_HI, 8'h0f);
      wr(arpwm_pkg::ADDR_DUTY0_HI + 8'h01, 8'hfe);
      wr(arpwm_pkg::ADDR_XFER, 8'h01);
      wr(arpwm_pkg::ADDR_OUT_EN, 8'h01);
      wr(arpwm_pkg::ADDR_CSR, 8'h11);
      run(1, 4);
      check("pwm set", {4'h0, pwm_o}, 8'h01);
      check("pwm owns pin", {4'h0, pwm_active_o}, 8'h01);
      rdc("transfer done", arpwm_pkg::ADDR_XFER, 8'h00);
      run(1, 2);
      check("pwm match", {4'h0, pwm_o}, 8'h00);
      check("cmp irq", {7'h0, irq_cmp_cap_o}, 8'h01);
      rdc("cmp flag", arpwm_pkg::ADDR_CH_CSR0, 8'h01);
      rdc("cmp cleared", arpwm_pkg::ADDR_CH_CSR0, 8'h00);
      wr(arpwm_pkg::ADDR_CH_CSR0, 8'h02);
      wr(arpwm_pkg::ADDR_XFER, 8'h01);
      run(1, 2);
      check("inverted high", {4'h0, pwm_o}, 8'h00);
      run(1, 2);
      check("inverted low", {4'h0, pwm_o}, 8'h01);
      wr(arpwm_pkg::ADDR_OUT_EN, 8'h00);
      wr(arpwm_pkg::ADDR_CSR, 8'h10);
      run(1, 4);
      check("pin released", {4'h0, pwm_active_o}, 8'h00);
      check("cmp masked", {7'h0, irq_cmp_cap_o}, 8'h00);
      rdc("cmp flag again", arpwm_pkg::ADDR_CH_CSR0, 8'h03);
   endtask

   // Capture runs with the clock off and on the cpu selection, never on the fast clock
   task automatic capture();
      wr(arpwm_pkg::ADDR_CSR, 8'h20);
      toggle_capture();
      check("cap irq", {7'h0, irq_cmp_cap_o}, 8'h01);
      rdc("cap flag", arpwm_pkg::ADDR_CSR, 8'h64);
      rdc("cap rising", arpwm_pkg::ADDR_CAP_LO, 8'hfe);
      wr(arpwm_pkg::ADDR_CSR, 8'h30);
      run(1, 2);
      toggle_capture();
      rdc("cap falling", arpwm_pkg::ADDR_CAP_LO, 8'hfc);
      rdc("cap hi", arpwm_pkg::ADDR_CAP_HI, 8'h0f);
      rdc("cap flag clear", arpwm_pkg::ADDR_CSR, 8'h34);
      check("cap irq off", {7'h0, irq_cmp_cap_o}, 8'h00);
      wr(arpwm_pkg::ADDR_CSR, 8'h70);
      rdc("flag write", arpwm_pkg::ADDR_CSR, 8'h30);
      run(1, 3);
      toggle_capture();
      rdc("cap again", arpwm_pkg::ADDR_CAP_LO, 8'hff);
   endtask

   task automatic break_test();
      wr(arpwm_pkg::ADDR_BREAK, 8'hc5);
      rdc("break top", arpwm_pkg::ADDR_BREAK, 8'h05);
      brk_req <= 1'b1;
      repeat (6) @(posedge mclk_i);
      rdc("pin ignored", arpwm_pkg::ADDR_BREAK, 8'h05);
      wr(arpwm_pkg::ADDR_BREAK, 8'h15);
      repeat (6) @(posedge mclk_i);
      rdc("break set", arpwm_pkg::ADDR_BREAK, 8'h35);
      check("pattern", {4'h0, pwm_o}, 8'h05);
      check("break owns", {4'h0, pwm_active_o}, 8'h0f);
      rdc("cnt cleared", arpwm_pkg::ADDR_CNT_LO, 8'h00);
      rdc("reload cleared", arpwm_pkg::ADDR_RLD_LO, 8'h00);
      rdc("duty cleared", arpwm_pkg::ADDR_DUTY0_HI, 8'h00);
      brk_req <= 1'b0;
      repeat (6) @(posedge mclk_i);
      wr(arpwm_pkg::ADDR_BREAK, 8'h00);
      rdc("break off", arpwm_pkg::ADDR_BREAK, 8'h00);
   endtask

   initial begin
      repeat (40000) @(posedge mclk_i);
      fail_count++;
      finish_test();
   end

   initial begin
      reset_n_i = 1'b0;
      tick = 3'h0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      cap_tgl = 1'b0;
      brk_req = 1'b0;
      repeat (20) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      reset_values();
      clock_select();
      overflow();
      pwm_and_compare();
      capture();
      break_test();
      finish_test();
   end
endmodule // testbench
`default_nettype wire
